//--- rtl/mdsbu_pkg.sv
//==========================================================
`default_nettype none
package mdsbu_pkg;
	localparam int DATA_W = 32;
	localparam logic STICKY_RESET = 1'b0;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam int DIV_CYCLES = 32;

	typedef enum logic [3:0] {
		OP_UNSIGNED_LONG_MULTIPLY,
		OP_UNSIGNED_LONG_MULTIPLY_ACCUMULATE,
		OP_SIGNED_LONG_MULTIPLY,
		OP_SIGNED_LONG_MULTIPLY_ACCUMULATE,
		OP_SIGNED_DIVIDE,
		OP_UNSIGNED_DIVIDE,
		OP_SIGNED_SATURATE,
		OP_UNSIGNED_SATURATE,
		OP_BITFIELD_CLEAR,
		OP_BITFIELD_INSERT,
		OP_STATUS_REGISTER_WRITE,
		OP_STATUS_REGISTER_READ
	} mdsbu_op_t;
endpackage

`default_nettype wire

//--- rtl/mdsbu_div_if.sv
`timescale 1ns/10ps
`default_nettype none
// carries one divide request and its answer between the unit and the divider
interface mdsbu_div_if;
	logic start;
	logic is_signed;
	logic [31:0] dividend;
	logic [31:0] divisor;
	logic done;
	logic [31:0] quotient;
	modport master (output start, output is_signed, output dividend, output divisor,
		input done, input quotient);
	modport slave (input start, input is_signed, input dividend, input divisor,
		output done, output quotient);
endinterface
`default_nettype wire

//--- rtl/mdsbu_divider.sv
`timescale 1ns/10ps
`default_nettype none
// restoring divider on magnitudes, one quotient bit per cycle
module mdsbu_divider
	import mdsbu_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	mdsbu_div_if.slave div
);
	logic busy;
	logic [5:0] count;
	logic [31:0] rem;
	logic [31:0] quo;
	logic [31:0] dvs;
	logic neg_q;
	logic zero_div;

	wire logic n_neg = div.is_signed & div.dividend[31];
	wire logic d_neg = div.is_signed & div.divisor[31];
	wire logic [31:0] n_mag = n_neg ? 32'(-div.dividend) : div.dividend;
	wire logic [31:0] d_mag = d_neg ? 32'(-div.divisor) : div.divisor;
	wire logic [32:0] trial = {rem, quo[31]} - {1'b0, dvs};
	wire logic fits = ~trial[32];
	wire logic [31:0] next_rem = fits ? trial[31:0] : {rem[30:0], quo[31]};
	wire logic [31:0] next_quo = {quo[30:0], fits};
	// magnitudes truncate, so the sign fix-up rounds toward zero
	wire logic [31:0] signed_quo = neg_q ? 32'(-quo) : quo;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			busy <= 1'b0;
			count <= 6'h00;
			rem <= 32'h00000000;
			quo <= 32'h00000000;
			dvs <= 32'h00000000;
			neg_q <= 1'b0;
			zero_div <= 1'b0;
			div.done <= 1'b0;
			div.quotient <= 32'h00000000;
		end
		else
		begin
			div.done <= 1'b0;
			if (div.start && !busy)
			begin
				busy <= 1'b1;
				count <= 6'(DIV_CYCLES);
				rem <= 32'h00000000;
				quo <= n_mag;
				dvs <= d_mag;
				neg_q <= n_neg ^ d_neg;
				zero_div <= (div.divisor == 32'h00000000);
			end
			else if (busy && count != 6'h00)
			begin
				rem <= next_rem;
				quo <= next_quo;
				count <= count - 6'h01;
			end
			else if (busy)
			begin
				busy <= 1'b0;
				div.done <= 1'b1;
				div.quotient <= zero_div ? 32'h00000000 : signed_quo;
			end
		end
	end
endmodule
`default_nettype wire

//--- rtl/mdsbu_unit.sv
`timescale 1ns/10ps
`default_nettype none
module mdsbu_unit
	import mdsbu_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic issue_valid,
	output logic issue_ready,
	input wire logic [3:0] op,
	input wire logic [31:0] first_operand,
	input wire logic [31:0] second_operand,
	input wire logic [31:0] low_destination,
	input wire logic [31:0] high_destination,
	input wire logic [4:0] shift_amount,
	input wire logic shift_is_asr,
	input wire logic [5:0] sat_width,
	input wire logic [4:0] field_lsb,
	input wire logic [5:0] field_width,
	input wire logic flag_update,
	input wire logic [3:0] flags_in,
	input wire logic sticky_in,
	output logic result_valid,
	output logic [31:0] result_low,
	output logic [31:0] result_high,
	output logic result_high_write,
	output logic [3:0] flags,
	output logic sticky_saturation
);
	//==========================================================
	// issue control
	typedef enum {ST_IDLE, ST_DIV} mdsbu_state_t;
	mdsbu_state_t state;
	mdsbu_div_if div_bus();
	mdsbu_op_t opc;
	assign opc = mdsbu_op_t'(op);

	mdsbu_divider u_div (
		.mclk(mclk),
		.resetn(resetn),
		.div(div_bus)
	);

	wire logic is_div = (opc == OP_SIGNED_DIVIDE) || (opc == OP_UNSIGNED_DIVIDE);
	assign issue_ready = (state == ST_IDLE);
	wire logic take = issue_valid && issue_ready;
	assign div_bus.start = take && is_div;
	assign div_bus.is_signed = (opc == OP_SIGNED_DIVIDE);
	assign div_bus.dividend = first_operand;
	assign div_bus.divisor = second_operand;

	//==========================================================
	// long multiply
	wire logic mul_signed = (opc == OP_SIGNED_LONG_MULTIPLY) ||
		(opc == OP_SIGNED_LONG_MULTIPLY_ACCUMULATE);
	wire logic mul_acc = (opc == OP_UNSIGNED_LONG_MULTIPLY_ACCUMULATE) ||
		(opc == OP_SIGNED_LONG_MULTIPLY_ACCUMULATE);
	wire logic is_mul = mul_signed || mul_acc || (opc == OP_UNSIGNED_LONG_MULTIPLY);
	wire logic [63:0] a_ext = {{32{mul_signed & first_operand[31]}}, first_operand};
	wire logic [63:0] b_ext = {{32{mul_signed & second_operand[31]}}, second_operand};
	// the low 64 bits of a sign-extended product equal the signed product
	wire logic [63:0] product = 64'(a_ext * b_ext);
	wire logic [63:0] acc_in = mul_acc ? {high_destination, low_destination} : 64'h0;
	wire logic [63:0] mul_sum = 64'(product + acc_in);

	//==========================================================
	// saturation with pre-shift
	wire logic [31:0] asr_val = 32'($signed(second_operand) >>> shift_amount);
	wire logic [31:0] lsl_val = 32'(second_operand << shift_amount);
	// an asr of zero is not a legal encoding, so zero means no shift either way
	wire logic [31:0] shifted = shift_is_asr ? asr_val : lsl_val;
	wire logic is_signed_saturate = (opc == OP_SIGNED_SATURATE);
	wire logic is_unsigned_saturate = (opc == OP_UNSIGNED_SATURATE);
	wire logic signed [32:0] sx = $signed({shifted[31], shifted});
	wire logic [5:0] sn_m1 = 6'(sat_width - 6'h01);
	wire logic signed [32:0] s_max = $signed(33'((33'h1 << sn_m1) - 33'h1));
	wire logic signed [32:0] s_min = $signed(33'(-(33'h1 << sn_m1)));
	wire logic signed [32:0] u_max = $signed(33'((33'h1 << sat_width) - 33'h1));
	logic [31:0] sat_val;
	always_comb
	begin
		sat_val = shifted;
		if (is_signed_saturate)
		begin
			if (sx > s_max)
				sat_val = s_max[31:0];
			else if (sx < s_min)
				sat_val = s_min[31:0];
		end
		else
		begin
			if (sx[32])
				sat_val = 32'h00000000;
			else if (sx > u_max)
				sat_val = u_max[31:0];
		end
	end
	wire logic clamped = (is_signed_saturate || is_unsigned_saturate) && (sat_val != shifted);

	//==========================================================
	// bitfield clear and insert
	wire logic [31:0] ones = 32'((33'h1 << field_width) - 33'h1);
	wire logic [31:0] field_mask = 32'(ones << field_lsb);
	wire logic [31:0] cleared = low_destination & ~field_mask;
	wire logic [31:0] inserted = cleared |
		(32'(first_operand << field_lsb) & field_mask);

	//==========================================================
	// result mux
	logic [31:0] next_low;
	always_comb
	begin
		case (opc)
			OP_SIGNED_SATURATE, OP_UNSIGNED_SATURATE: next_low = sat_val;
			OP_BITFIELD_CLEAR: next_low = cleared;
			OP_BITFIELD_INSERT: next_low = inserted;
			OP_STATUS_REGISTER_READ: next_low = {flags, sticky_saturation, 27'h0000000};
			default: next_low = mul_sum[31:0];
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			state <= ST_IDLE;
			result_valid <= 1'b0;
			result_low <= 32'h00000000;
			result_high <= 32'h00000000;
			result_high_write <= 1'b0;
		end
		else
		begin
			result_valid <= 1'b0;
			result_high_write <= 1'b0;
			case (state)
				ST_IDLE:
					if (take && is_div)
						state <= ST_DIV;
					else if (take && opc != OP_STATUS_REGISTER_WRITE)
					begin
						result_valid <= 1'b1;
						result_low <= next_low;
						result_high <= is_mul ? mul_sum[63:32] : 32'h00000000;
						result_high_write <= is_mul;
					end
				ST_DIV:
					if (div_bus.done)
					begin
						state <= ST_IDLE;
						result_valid <= 1'b1;
						result_low <= div_bus.quotient;
						result_high <= 32'h00000000;
					end
				default: state <= ST_IDLE;
			endcase
		end
	end

	//==========================================================
	// flags: no operation here changes nzcv unless explicitly written
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			flags <= FLAGS_RESET;
			sticky_saturation <= STICKY_RESET;
		end
		else if (take)
		begin
			// set wins when a saturation and a write coincide only if the write keeps it
			if (opc == OP_STATUS_REGISTER_WRITE)
			begin
				flags <= flag_update ? flags_in : flags;
				sticky_saturation <= sticky_in;
			end
			else if (clamped)
				sticky_saturation <= 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- sim/mdsbu_regfile.sv
`timescale 1ns/10ps
`default_nettype none
// register-file model: two distinct accumulator registers fed back to the unit
// only general data registers are modelled, never stack pointer or program counter
module mdsbu_regfile
(
	input wire logic mclk,
	input wire logic preset,
	input wire logic [31:0] preset_low,
	input wire logic [31:0] preset_high,
	input wire logic result_valid,
	input wire logic [31:0] result_low,
	input wire logic [31:0] result_high,
	input wire logic result_high_write,
	output logic [31:0] low_destination,
	output logic [31:0] high_destination
);
	always_ff @(posedge mclk)
	begin
		if (preset)
		begin
			low_destination <= preset_low;
			high_destination <= preset_high;
		end
		else if (result_valid)
		begin
			low_destination <= result_low;
			if (result_high_write)
				high_destination <= result_high;
		end
	end
endmodule
`default_nettype wire

//--- sim/mdsbu_unit_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module mdsbu_unit_asserts
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic issue_valid,
	input wire logic issue_ready,
	input wire logic [3:0] op,
	input wire logic [31:0] first_operand,
	input wire logic [31:0] second_operand,
	input wire logic [31:0] low_destination,
	input wire logic [5:0] field_width,
	input wire logic flag_update,
	input wire logic result_valid,
	input wire logic [31:0] result_low,
	input wire logic result_high_write,
	input wire logic [3:0] flags,
	input wire logic sticky_saturation
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	logic take;
	assign take = issue_valid && issue_ready;
	sequence div_take;
		take && (op == 4'h4 || op == 4'h5);
	endsequence
	sequence div_wait;
		(!result_valid && !issue_ready) [*8] ##26 (!result_valid && !issue_ready) ##1
			(result_valid && issue_ready);
	endsequence
	mul_latency_a: assert property (take && op < 4'h4 |=> result_valid && result_high_write)
		else $error("multiply result not one cycle after issue");
	div_latency_a: assert property (div_take |=> div_wait)
		else $error("divide timing wrong");
	div_zero_a: assert property (take && (op == 4'h4 || op == 4'h5) && second_operand == 32'h0 |-> ##35 (result_valid && result_low == 32'h0))
		else $error("divide by zero not zero");
	flags_hold_a: assert property (!$stable(flags) |-> $past(take && op == 4'hA && flag_update))
		else $error("flags changed without request");
	sticky_set_a: assert property ($rose(sticky_saturation) |-> $past(take && op inside {4'h6, 4'h7, 4'hA}))
		else $error("sticky set without cause");
	sticky_clear_a: assert property ($fell(sticky_saturation) |-> $past(take && op == 4'hA))
		else $error("sticky cleared without status write");
	status_read_a: assert property (take && op == 4'hB |=> result_low == {$past(flags), $past(sticky_saturation), 27'h0})
		else $error("status read wrong");
	field_clear_a: assert property (take && op == 4'h8 |=> (result_low & ~$past(low_destination)) == 32'h0)
		else $error("clear set a bit");
	field_full_a: assert property (take && op == 4'h9 && field_width == 6'h20 |=> result_low == $past(first_operand))
		else $error("full insert wrong");
endmodule
bind mdsbu_unit mdsbu_unit_asserts u_chk (.mclk, .resetn, .issue_valid, .issue_ready, .op,
	.first_operand, .second_operand, .low_destination, .field_width, .flag_update,
	.result_valid, .result_low, .result_high_write, .flags, .sticky_saturation);
`default_nettype wire

//--- sim/mdsbu_unit_bench.sv
`timescale 1ns/10ps
`default_nettype none
module mdsbu_unit_bench;
	logic mclk, resetn, issue_valid, shift_is_asr, flag_update, sticky_in, preset, m_sticky;
	logic issue_ready, result_valid, result_high_write, sticky_saturation;
	logic [3:0] op, flags_in, flags, m_flags;
	logic [4:0] shamt, lsb;
	logic [5:0] satw, fw;
	logic [31:0] a, b, plo, phi, lo, hi, result_low, result_high, m_lo, m_hi, e_lo, e_hi;
	logic [63:0] p, mask;
	longint v, r, lim;
	int error_cnt, num_checks, seed, i, k;
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	mdsbu_unit u_dut (.mclk(mclk), .resetn(resetn), .issue_valid(issue_valid),
		.issue_ready(issue_ready), .op(op), .first_operand(a), .second_operand(b),
		.low_destination(lo), .high_destination(hi), .shift_amount(shamt),
		.shift_is_asr(shift_is_asr), .sat_width(satw), .field_lsb(lsb), .field_width(fw),
		.flag_update(flag_update), .flags_in(flags_in), .sticky_in(sticky_in),
		.result_valid(result_valid), .result_low(result_low), .result_high(result_high),
		.result_high_write(result_high_write), .flags(flags),
		.sticky_saturation(sticky_saturation));
	mdsbu_regfile u_rf (.mclk(mclk), .preset(preset), .preset_low(plo), .preset_high(phi),
		.result_valid(result_valid), .result_low(result_low), .result_high(result_high),
		.result_high_write(result_high_write), .low_destination(lo), .high_destination(hi));
	task conclude;
		if (error_cnt == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// model first, from mirrors of the register file, then drive and compare
	task run_op;
		e_hi = 32'h0;
		e_lo = 32'h0;
		mask = ((64'h1 << fw) - 64'h1) << lsb;
		p = op[1] ? 64'(longint'($signed(a)) * longint'($signed(b))) : {32'h0, a} * {32'h0, b};
		if (op[0])
			p = p + {m_hi, m_lo};
		v = shift_is_asr ? longint'($signed(b) >>> shamt) : longint'($signed(b << shamt));
		lim = (op == 4'h6) ? (longint'(1) << (satw - 1)) : (longint'(1) << satw) - 1;
		r = (op == 4'h6) ? (v > lim - 1 ? lim - 1 : (v < -lim ? -lim : v)) : (v < 0 ? 0 : (v > lim ? lim : v));
		case (op)
			4'h0, 4'h1, 4'h2, 4'h3: {e_hi, e_lo} = p;
			4'h4: e_lo = (b == 32'h0) ? 32'h0 : 32'(longint'($signed(a)) / longint'($signed(b)));
			4'h5: e_lo = (b == 32'h0) ? 32'h0 : 32'(longint'(a) / longint'(b));
			4'h6, 4'h7: e_lo = r[31:0];
			4'h8, 4'h9: e_lo = (m_lo & ~mask[31:0]) | (op[0] ? (a << lsb) & mask[31:0] : 32'h0);
			4'hB: e_lo = {m_flags, m_sticky, 27'h0};
			default: e_lo = 32'h0;
		endcase
		if ((op == 4'h6 || op == 4'h7) && r != v)
			m_sticky = 1'b1;
		if (op == 4'hA)
		begin
			m_sticky = sticky_in;
			if (flag_update)
				m_flags = flags_in;
		end
		for (k = 0; k < 40 && issue_ready !== 1'b1; k++)
			@(negedge mclk);
		if (issue_ready !== 1'b1)
		begin
			error_cnt++;
			conclude();
		end
		issue_valid = 1'b1;
		@(negedge mclk);
		issue_valid = 1'b0;
		if (op != 4'hA)
		begin
			for (k = 0; k < 40 && result_valid !== 1'b1; k++)
				@(negedge mclk);
			if (result_valid !== 1'b1)
			begin
				error_cnt++;
				conclude();
			end
			chk("result_low", e_lo, result_low);
			chk("result_high", e_hi, result_high);
			chk("high_write", 32'(op < 4'h4), 32'(result_high_write));
			m_lo = e_lo;
			if (op < 4'h4)
				m_hi = e_hi;
			// the register file writes back one edge after result_valid
			@(negedge mclk);
		end
		chk("flags", 32'(m_flags), 32'(flags));
		chk("sticky", 32'(m_sticky), 32'(sticky_saturation));
	endtask
	initial
	begin
		{issue_valid, shift_is_asr, flag_update, sticky_in, preset, m_sticky} = 6'h0;
		{op, flags_in, m_flags, shamt, lsb, satw, fw} = 34'h0;
		{a, b, plo, phi} = 128'h0;
		seed = 32'h4E5600A6;
		resetn = 1'b0;
		repeat (20) @(negedge mclk);
		resetn = 1'b1;
		for (i = 0; i < 400; i++)
		begin
			if (i % 5 == 0)
			begin
				plo = $random(seed);
				phi = $random(seed);
				preset = 1'b1;
				@(negedge mclk);
				preset = 1'b0;
				m_lo = plo;
				m_hi = phi;
			end
			op = (i < 24) ? 4'(i % 12) : 4'($unsigned($random(seed)) % 12);
			a = $random(seed);
			b = (i % 7 == 0) ? 32'h0 : $random(seed);
			{shift_is_asr, flag_update, sticky_in, flags_in, shamt, lsb} = 17'($random(seed));
			if (shift_is_asr && shamt == 5'h0)
				shamt = 5'h1;
			satw = 6'((op == 4'h6) + $unsigned($random(seed)) % 32);
			fw = 6'(1 + $unsigned($random(seed)) % (32 - lsb));
			if (i % 50 == 9)
			begin
				op = 4'h9;
				lsb = 5'h00;
				fw = 6'h20;
			end
			run_op();
		end
		conclude();
	end
endmodule
`default_nettype wire
